// ===== nfc_pkg.sv
package nfc_pkg;
  // command bytes
  localparam logic [7:0] CMD_READ_ADDR = 8'h00;
  localparam logic [7:0] CMD_READ_START = 8'h30;
  localparam logic [7:0] CMD_DATA_IN = 8'h80;
  localparam logic [7:0] CMD_PROGRAM = 8'h10;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
  localparam logic [7:0] CMD_ERASE_START = 8'hD0;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_RESET = 8'hFF;
  // host operation codes
  localparam logic [2:0] OP_READ = 3'h0;
  localparam logic [2:0] OP_PROGRAM = 3'h1;
  localparam logic [2:0] OP_ERASE = 3'h2;
  localparam logic [2:0] OP_STATUS = 3'h3;
  localparam logic [2:0] OP_RESET = 3'h4;
  localparam int CLK_NS = 20;
  // pin timing in ns
  localparam int WRITE_PULSE_NS = 25;
  localparam int WRITE_HIGH_NS = 15;
  localparam int READ_PULSE_NS = 35;
  localparam int READ_HIGH_NS = 15;
  localparam int STROBE_ACCESS_TIME_NS = 35;
  localparam int WE_HIGH_TO_BUSY_NS = 200;
  localparam int WP_HIGH_TO_WE_NS = 100;
  localparam int READY_TO_STROBE_NS = 20;
  localparam int HOLD_NS = 10;
  // least times round up
  localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int WRITE_HIGH_CYC = (WRITE_HIGH_NS + CLK_NS - 1) / CLK_NS;
  localparam int READ_PULSE_CYC = (READ_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int READ_HIGH_CYC = (READ_HIGH_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACCESS_CYC = (STROBE_ACCESS_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int BUSY_WAIT_CYC = (WE_HIGH_TO_BUSY_NS + CLK_NS - 1) / CLK_NS;
  localparam int WP_SETUP_CYC = (WP_HIGH_TO_WE_NS + CLK_NS - 1) / CLK_NS;
  localparam int READY_CYC = (READY_TO_STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int ADDR_BYTES = 4;
  localparam int SEGMENT_BYTES = 512 + 16;
  localparam int MAX_PROGRAMS = 2;
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int LEN_W = 12;
  localparam int TMR_W = 4;
endpackage

// ===== nfc_stream_if.sv
`timescale 1ns/100ps
`default_nettype none
interface nfc_stream_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport source (output valid, output data, input ready);
  modport sink (input valid, input data, output ready);
endinterface
`default_nettype wire

// ===== nfc_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module nfc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic flush, // drop all contents
  nfc_stream_if.sink wr, // filling side
  nfc_stream_if.source rd // draining side
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wp, rp, next_wp, next_rp;
  logic do_wr, do_rd;
  assign wr.ready = (wp - rp) != (AW+1)'(DEPTH);
  assign rd.valid = wp != rp;
  assign rd.data = mem[rp[AW-1:0]];
  assign do_wr = wr.valid && wr.ready;
  assign do_rd = rd.valid && rd.ready;
  always_comb begin
    next_wp = wp;
    next_rp = rp;
    if (flush) begin
      next_wp = '0;
      next_rp = '0;
    end else begin
      if (do_wr) next_wp = wp + 1'b1;
      if (do_rd) next_rp = rp + 1'b1;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp <= '0;
      rp <= '0;
    end else begin
      wp <= next_wp;
      rp <= next_rp;
    end
  end
  // storage has no reset; contents are only read behind the pointers
  always_ff @(posedge clk) begin
    if (do_wr && !flush) mem[wp[AW-1:0]] <= wr.data;
  end
endmodule
`default_nettype wire

// ===== nfc_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module nfc_ctrl (
  input wire logic clk, // 50 MHz system clock
  input wire logic rst_n, // async reset, active low
  input wire logic op_valid, // operation request
  output logic op_ready, // controller idle, takes request
  input wire logic [2:0] op_code, // nfc_pkg::OP_READ .. OP_RESET
  input wire logic [11:0] op_column, // column address
  input wire logic [15:0] op_page, // page/block address
  input wire logic [nfc_pkg::LEN_W-1:0] op_length, // bytes to move, 0 means none
  input wire logic op_write_enable, // allow program and erase
  output logic op_done, // one-cycle pulse at end of operation
  output logic [7:0] status_byte, // last status read byte
  input wire logic wr_valid, // program data valid
  output logic wr_ready, // program data taken into fifo, except in ST_IDLE where the flush drops it
  input wire logic [7:0] wr_data, // program data byte
  output logic rd_valid, // read data valid
  input wire logic rd_ready, // read data consumer ready
  output logic [7:0] rd_data, // read data byte
  output logic cmd_latch, // command latch select
  output logic addr_latch, // address latch select
  output logic chip_select_n, // chip select, active low
  output logic write_strobe_n, // write strobe, active low
  output logic output_strobe_n, // output strobe, active low
  output logic write_protect_n, // write protect, active low
  input wire logic ready_busy_n, // ready/busy from open-drain pin
  input wire logic [7:0] shared_byte_port_in, // byte port sensed value
  output logic [7:0] shared_byte_port_out, // byte port driven value
  output logic shared_byte_port_oe // byte port output enable
);
  import nfc_pkg::*;

  typedef enum {
    ST_IDLE, ST_WP, ST_CMD1, ST_ADDR, ST_DATA, ST_CMD2, ST_WAIT_BUSY, ST_WAIT_READY,
    ST_READ, ST_STATUS_CMD, ST_STATUS_RD, ST_DONE
  } nfc_state_type;

  nfc_state_type state, next_state;
  logic [TMR_W-1:0] tmr, next_tmr;
  logic [1:0] phase, next_phase;
  logic [2:0] op, next_op;
  logic [1:0] abyte, next_abyte;
  logic [11:0] col, next_col;
  logic [15:0] page, next_page;
  logic [LEN_W-1:0] cnt, next_cnt;
  logic [7:0] sbyte, next_sbyte;
  logic wp_en, next_wp_en;
  logic cle, next_cle, ale, next_ale, we_n, next_we_n, re_n, next_re_n, ce_n, next_ce_n;
  logic [7:0] dout, next_dout;
  logic oe, next_oe;
  logic rb_meta, rb_sync;
  logic [7:0] io_meta, io_sync;
  logic fifo_take;

  nfc_stream_if #(.W(FIFO_WIDTH)) wr_in ();
  nfc_stream_if #(.W(FIFO_WIDTH)) wr_out ();

  assign wr_in.valid = wr_valid;
  assign wr_in.data = wr_data;
  assign wr_ready = wr_in.ready;
  assign wr_out.ready = fifo_take;

  nfc_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .flush(state == ST_IDLE),
    .wr(wr_in),
    .rd(wr_out)
  );

  function automatic logic [7:0] addr_byte(input logic [1:0] idx, input logic [11:0] c,
                                           input logic [15:0] p);
    case (idx)
      2'd0: addr_byte = c[7:0];
      2'd1: addr_byte = {4'h0, c[11:8]};
      2'd2: addr_byte = p[7:0];
      default: addr_byte = p[15:8];
    endcase
  endfunction

  function automatic logic [7:0] first_cmd(input logic [2:0] o);
    case (o)
      OP_READ: first_cmd = CMD_READ_ADDR;
      OP_PROGRAM: first_cmd = CMD_DATA_IN;
      OP_ERASE: first_cmd = CMD_ERASE_SETUP;
      OP_STATUS: first_cmd = CMD_STATUS;
      default: first_cmd = CMD_RESET;
    endcase
  endfunction

  // pins from the device cross two flops before any logic reads them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rb_meta <= 1'b1;
      rb_sync <= 1'b1;
      io_meta <= 8'h00;
      io_sync <= 8'h00;
    end else begin
      rb_meta <= ready_busy_n;
      rb_sync <= rb_meta;
      io_meta <= shared_byte_port_in;
      io_sync <= io_meta;
    end
  end

  // one write cycle: phase 0 strobe low, phase 1 strobe high, phase 2 hold
  always_comb begin
    next_state = state;
    next_tmr = tmr;
    next_phase = phase;
    next_op = op;
    next_abyte = abyte;
    next_col = col;
    next_page = page;
    next_cnt = cnt;
    next_sbyte = sbyte;
    next_wp_en = wp_en;
    next_cle = cle;
    next_ale = ale;
    next_we_n = we_n;
    next_re_n = re_n;
    next_ce_n = ce_n;
    next_dout = dout;
    next_oe = oe;
    fifo_take = 1'b0;
    op_ready = 1'b0;
    if (tmr != '0) begin
      next_tmr = tmr - 1'b1;
    end else begin
      case (state)
        ST_IDLE: begin
          op_ready = rb_sync || op_code == OP_STATUS || op_code == OP_RESET;
          next_ce_n = 1'b1;
          next_oe = 1'b0;
          next_wp_en = 1'b0;
          if (op_valid && op_ready) begin
            next_op = op_code;
            next_col = op_column;
            next_page = op_page;
            next_cnt = op_length;
            next_abyte = (op_code == OP_ERASE) ? 2'd2 : 2'd0;
            next_ce_n = 1'b0;
            next_phase = 2'd0;
            if ((op_code == OP_PROGRAM || op_code == OP_ERASE) && op_write_enable) begin
              next_wp_en = 1'b1;
              next_state = ST_WP;
              next_tmr = TMR_W'(WP_SETUP_CYC);
            end else if (op_code == OP_PROGRAM || op_code == OP_ERASE) begin
              next_state = ST_DONE;
            end else begin
              next_state = ST_CMD1;
            end
          end
        end
        ST_WP: next_state = ST_CMD1;
        ST_CMD1, ST_ADDR, ST_DATA, ST_CMD2, ST_STATUS_CMD: begin
          case (phase)
            2'd0: begin
              if (state == ST_DATA && !wr_out.valid) begin
                next_phase = 2'd0; // source stalls, strobe waits
              end else begin
                next_cle = state == ST_CMD1 || state == ST_CMD2 || state == ST_STATUS_CMD;
                next_ale = state == ST_ADDR;
                next_oe = 1'b1;
                if (state == ST_CMD1) next_dout = first_cmd(op);
                else if (state == ST_STATUS_CMD) next_dout = CMD_STATUS;
                else if (state == ST_ADDR) next_dout = addr_byte(abyte, col, page);
                else if (state == ST_DATA) next_dout = wr_out.data;
                else if (op == OP_READ) next_dout = CMD_READ_START;
                else if (op == OP_PROGRAM) next_dout = CMD_PROGRAM;
                else next_dout = CMD_ERASE_START;
                fifo_take = state == ST_DATA;
                next_we_n = 1'b0;
                next_phase = 2'd1;
                next_tmr = TMR_W'(WRITE_PULSE_CYC - 1);
              end
            end
            2'd1: begin
              next_we_n = 1'b1;
              next_phase = 2'd2;
              next_tmr = TMR_W'(HOLD_CYC - 1);
            end
            default: begin
              next_cle = 1'b0;
              next_ale = 1'b0;
              next_phase = 2'd0;
              next_tmr = TMR_W'(WRITE_HIGH_CYC - 1);
              case (state)
                ST_CMD1:
                  if (op == OP_STATUS) next_state = ST_STATUS_RD;
                  else if (op == OP_RESET) next_state = ST_WAIT_BUSY;
                  else next_state = ST_ADDR;
                ST_ADDR: begin
                  next_abyte = abyte + 1'b1;
                  if (abyte == 2'(ADDR_BYTES - 1))
                    next_state = (op == OP_PROGRAM && cnt != '0) ? ST_DATA : ST_CMD2;
                end
                ST_DATA: begin
                  next_cnt = cnt - 1'b1;
                  if (cnt == LEN_W'(1)) next_state = ST_CMD2;
                end
                ST_CMD2: next_state = ST_WAIT_BUSY;
                default: next_state = ST_STATUS_RD;
              endcase
              if (state != ST_DATA) next_oe = 1'b0;
            end
          endcase
        end
        ST_WAIT_BUSY: begin
          next_oe = 1'b0;
          next_state = ST_WAIT_READY;
          next_tmr = TMR_W'(BUSY_WAIT_CYC + 2); // busy shows up, then passes the sync
        end
        ST_WAIT_READY: begin
          // no timeout: the device bounds array load and reset itself
          // chip select stays low while busy; the device would ignore it anyway
          if (rb_sync) begin
            next_wp_en = 1'b0;
            next_tmr = TMR_W'(READY_CYC);
            if (op == OP_READ && cnt != '0) next_state = ST_READ;
            else if (op == OP_PROGRAM || op == OP_ERASE) next_state = ST_STATUS_CMD;
            else next_state = ST_DONE;
          end
        end
        ST_READ: begin
          case (phase)
            2'd0: begin
              if (rd_ready || !rd_valid) begin
                next_re_n = 1'b0;
                next_phase = 2'd1;
                next_tmr = TMR_W'(ACCESS_CYC + 1); // access time plus sync delay
              end
            end
            default: begin
              next_re_n = 1'b1;
              next_phase = 2'd0;
              next_cnt = cnt - 1'b1;
              next_tmr = TMR_W'(READ_HIGH_CYC - 1);
              if (cnt == LEN_W'(1)) next_state = ST_DONE;
            end
          endcase
        end
        ST_STATUS_RD: begin
          case (phase)
            2'd0: begin
              next_re_n = 1'b0;
              next_phase = 2'd1;
              next_tmr = TMR_W'(ACCESS_CYC + 1);
            end
            default: begin
              next_re_n = 1'b1;
              next_sbyte = io_sync;
              next_phase = 2'd0;
              next_state = ST_DONE;
            end
          endcase
        end
        default: begin
          next_ce_n = 1'b1;
          next_wp_en = 1'b0;
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      tmr <= '0;
      phase <= 2'd0;
      op <= OP_READ;
      abyte <= 2'd0;
      col <= '0;
      page <= '0;
      cnt <= '0;
      sbyte <= 8'h00;
      wp_en <= 1'b0;
      cle <= 1'b0;
      ale <= 1'b0;
      we_n <= 1'b1;
      re_n <= 1'b1;
      ce_n <= 1'b1;
      dout <= 8'h00;
      oe <= 1'b0;
    end else begin
      state <= next_state;
      tmr <= next_tmr;
      phase <= next_phase;
      op <= next_op;
      abyte <= next_abyte;
      col <= next_col;
      page <= next_page;
      cnt <= next_cnt;
      sbyte <= next_sbyte;
      wp_en <= next_wp_en;
      cle <= next_cle;
      ale <= next_ale;
      we_n <= next_we_n;
      re_n <= next_re_n;
      ce_n <= next_ce_n;
      dout <= next_dout;
      oe <= next_oe;
    end
  end

  // read byte captured when the strobe rises, after the access time has passed
  logic rv, next_rv;
  logic [7:0] rdat, next_rdat;
  always_comb begin
    next_rv = rv && !rd_ready;
    next_rdat = rdat;
    if (state == ST_READ && phase == 2'd1 && tmr == '0) begin
      next_rv = 1'b1;
      next_rdat = io_sync;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rv <= 1'b0;
      rdat <= 8'h00;
    end else begin
      rv <= next_rv;
      rdat <= next_rdat;
    end
  end

  assign rd_valid = rv;
  assign rd_data = rdat;
  assign op_done = state == ST_DONE && tmr == '0;
  assign status_byte = sbyte;
  assign cmd_latch = cle;
  assign addr_latch = ale;
  assign chip_select_n = ce_n;
  assign write_strobe_n = we_n;
  assign output_strobe_n = re_n;
  assign write_protect_n = wp_en;
  assign shared_byte_port_out = dout;
  assign shared_byte_port_oe = oe;
endmodule
`default_nettype wire

// ===== nfc_ctrl_props.sv
`timescale 1ns/100ps
`default_nettype none
module nfc_ctrl_props (
  input wire logic clk, // clock
  input wire logic rst_n, // reset, active low
  input wire logic op_valid, // request
  input wire logic op_done, // end pulse
  input wire logic rd_valid, // read valid
  input wire logic rd_ready, // read ready
  input wire logic [7:0] rd_data, // read byte
  input wire logic cmd_latch, // command select
  input wire logic addr_latch, // address select
  input wire logic chip_select_n, // chip select
  input wire logic write_strobe_n, // write strobe
  input wire logic output_strobe_n, // output strobe
  input wire logic write_protect_n, // write protect
  input wire logic ready_busy_n, // ready/busy pin
  input wire logic [7:0] shared_byte_port_out, // driven byte
  input wire logic shared_byte_port_oe // drive enable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_one_select;
    !(cmd_latch && addr_latch);
  endproperty
  a_one_select: assert property (p_one_select) else $error("both selects high");
  property p_one_strobe;
    !(!write_strobe_n && !output_strobe_n);
  endproperty
  a_one_strobe: assert property (p_one_strobe) else $error("both strobes low");
  property p_write_drive;
    !write_strobe_n |-> shared_byte_port_oe && !chip_select_n;
  endproperty
  a_write_drive: assert property (p_write_drive) else $error("write byte not driven");
  property p_write_pulse;
    $fell(write_strobe_n) |-> !write_strobe_n [*2];
  endproperty
  a_write_pulse: assert property (p_write_pulse) else $error("write pulse short");
  // the byte and selects must still stand at the rising strobe edge
  property p_write_hold;
    ($past(write_strobe_n) == 1'b0) |-> $stable({cmd_latch, addr_latch, shared_byte_port_out});
  endproperty
  a_write_hold: assert property (p_write_hold) else $error("byte moved in write");
  property p_read_pulse;
    $fell(output_strobe_n) |-> !output_strobe_n [*4] ##1 output_strobe_n;
  endproperty
  a_read_pulse: assert property (p_read_pulse) else $error("read pulse length");
  property p_read_release;
    !output_strobe_n |-> !shared_byte_port_oe && !chip_select_n;
  endproperty
  a_read_release: assert property (p_read_release) else $error("port driven in read");
  property p_read_ready;
    $fell(output_strobe_n) |-> ready_busy_n && $past(ready_busy_n);
  endproperty
  a_read_ready: assert property (p_read_ready) else $error("read while busy");
  property p_wp_idle;
    op_done |=> !write_protect_n;
  endproperty
  a_wp_idle: assert property (p_wp_idle) else $error("protect high when idle");
  property p_rd_hold;
    rd_valid && !rd_ready |=> rd_valid && $stable(rd_data);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read byte dropped");
  c_read: cover property ($fell(output_strobe_n));
  c_busy: cover property ($fell(ready_busy_n));
  c_done: cover property (op_done);
endmodule
bind nfc_ctrl nfc_ctrl_props chk_u (.clk, .rst_n, .op_valid, .op_done, .rd_valid, .rd_ready,
  .rd_data, .cmd_latch, .addr_latch, .chip_select_n, .write_strobe_n, .output_strobe_n,
  .write_protect_n, .ready_busy_n, .shared_byte_port_out, .shared_byte_port_oe);
`default_nettype wire

// ===== nfc_flash_model.sv
`timescale 1ns/100ps
`default_nettype none
module nfc_flash_model #(
  parameter int LOAD_NS = 25000,
  parameter int PROG_NS = 4000,
  parameter int ERASE_NS = 6000,
  parameter int RESET_NS = 6000
) (
  input wire logic cmd_latch, // command select
  input wire logic addr_latch, // address select
  input wire logic chip_select_n, // chip select
  input wire logic write_strobe_n, // write strobe
  input wire logic output_strobe_n, // output strobe
  input wire logic write_protect_n, // write protect
  input wire logic [7:0] shared_byte_port_in, // byte on the port
  output logic busy_pull, // pulls ready/busy low
  output logic [7:0] dq // byte offered to host
);
  logic [7:0] arr [int];
  logic [7:0] pend [int];
  logic [7:0] abyte [4];
  logic [7:0] last_cmd;
  logic [11:0] col;
  logic [15:0] page;
  logic status_mode;
  logic standby;
  int n_addr;
  int n_cmd;
  int key;
  assign standby = chip_select_n && !busy_pull;
  initial begin
    busy_pull = 1'b0;
    dq = 8'h5A;
    status_mode = 1'b0;
    n_addr = 0;
    n_cmd = 0;
  end
  // the write strobe process sleeps here, so write cycles are ignored while busy; the output strobe is still served
  task automatic go_busy(input int ns);
    busy_pull = 1'b1;
    #(ns);
    busy_pull = 1'b0;
  endtask
  always @(posedge write_strobe_n) begin
    if (!chip_select_n && cmd_latch) begin
      n_cmd++;
      last_cmd = shared_byte_port_in;
      case (shared_byte_port_in)
        8'h00, 8'h80, 8'h60: begin
          n_addr = 0;
          status_mode = 1'b0;
        end
        8'h30: go_busy(LOAD_NS);
        8'h10: begin
          if (write_protect_n) foreach (pend[k]) arr[k] = pend[k];
          pend.delete();
          go_busy(PROG_NS);
        end
        8'hD0: begin
          if (write_protect_n) arr.delete();
          go_busy(ERASE_NS);
        end
        8'h70: status_mode = 1'b1;
        8'hFF: go_busy(RESET_NS);
        default: ;
      endcase
    end else if (!chip_select_n && addr_latch) begin
      if (n_addr < 4) abyte[n_addr] = shared_byte_port_in;
      n_addr++;
      col = {abyte[1][3:0], abyte[0]};
      page = {abyte[3], abyte[2]};
    end else if (!chip_select_n) begin
      pend[{4'h0, page, col}] = shared_byte_port_in;
      col++;
    end
  end
  always @(negedge output_strobe_n) begin
    if (!chip_select_n) begin
      key = {4'h0, page, col};
      if (!status_mode) col++;
      dq = ~dq;
      #30;
      dq = status_mode ? 8'hE0 : (arr.exists(key) ? arr[key] : 8'hFF);
    end
  end
  // past the hold time the old byte must not be trusted
  always @(posedge output_strobe_n) begin
    #10;
    dq = ~dq;
  end
endmodule
`default_nettype wire

// ===== nfc_ctrl_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module nfc_ctrl_tb_top;
  import nfc_pkg::*;
  localparam int LIM = 20000;
  logic clk, rst_n, op_valid, op_ready, op_write_enable, op_done, wr_valid, wr_ready;
  logic rd_valid, rd_ready, cmd_latch, addr_latch, chip_select_n, write_strobe_n;
  logic output_strobe_n, write_protect_n, ready_busy_n, shared_byte_port_oe, busy_pull;
  logic [2:0] op_code;
  logic [11:0] op_column;
  logic [15:0] op_page;
  logic [LEN_W-1:0] op_length;
  logic [7:0] status_byte, wr_data, rd_data, shared_byte_port_in, shared_byte_port_out, dq;
  int fails, checks;
  assign ready_busy_n = busy_pull ? 1'b0 : 1'b1;
  assign shared_byte_port_in = shared_byte_port_oe ? shared_byte_port_out : dq;
  nfc_ctrl dut_u (.clk, .rst_n, .op_valid, .op_ready, .op_code, .op_column, .op_page,
    .op_length, .op_write_enable, .op_done, .status_byte, .wr_valid, .wr_ready, .wr_data,
    .rd_valid, .rd_ready, .rd_data, .cmd_latch, .addr_latch, .chip_select_n, .write_strobe_n,
    .output_strobe_n, .write_protect_n, .ready_busy_n, .shared_byte_port_in,
    .shared_byte_port_out, .shared_byte_port_oe);
  nfc_flash_model flash_u (.cmd_latch, .addr_latch, .chip_select_n, .write_strobe_n,
    .output_strobe_n, .write_protect_n, .shared_byte_port_in, .busy_pull, .dq);
  always #(CLK_NS / 2) clk = ~clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic run_op(input logic [2:0] code, input logic [15:0] pg, input logic [11:0] col,
      input logic [11:0] len, input logic we);
    int n;
    n = 0;
    @(posedge clk);
    op_valid <= 1'b1;
    op_code <= code;
    op_page <= pg;
    op_column <= col;
    op_length <= len;
    op_write_enable <= we;
    do begin
      @(negedge clk);
      n++;
    end while (op_ready !== 1'b1 && n < LIM);
    check(n < LIM, 1'b1);
    @(posedge clk);
    op_valid <= 1'b0;
  endtask
  task automatic wait_done;
    int n;
    n = 0;
    while (op_done !== 1'b1 && n < LIM) begin
      @(negedge clk);
      n++;
    end
    check(n < LIM, 1'b1);
  endtask
  task automatic push(input int n, input logic [7:0] base, output int full);
    int i;
    i = 0;
    full = 0;
    @(posedge clk);
    wr_valid <= 1'b1;
    wr_data <= base;
    while (i < n) begin
      @(negedge clk);
      if (wr_ready === 1'b1) i++;
      else full++;
      @(posedge clk);
      wr_data <= base + i[7:0];
      wr_valid <= (i < n);
    end
  endtask
  // consumer stalls every other cycle to exercise the hold on read data
  task automatic pull(input int n, input logic [7:0] base);
    int i;
    i = 0;
    while (i < n) begin
      @(posedge clk);
      rd_ready <= ~rd_ready;
      @(negedge clk);
      if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
        check(rd_data, base + i[7:0]);
        i++;
      end
    end
    @(posedge clk);
    rd_ready <= 1'b0;
  endtask
  task automatic read_chk(input logic [15:0] pg, input logic [11:0] col, input int n,
      input logic [7:0] base);
    run_op(OP_READ, pg, col, n[11:0], 1'b1);
    fork
      pull(n, base);
      wait_done;
    join
  endtask
  task automatic t_reset;
    @(negedge clk);
    check({write_protect_n, chip_select_n, write_strobe_n, output_strobe_n}, 4'h7);
    check({cmd_latch, addr_latch, shared_byte_port_oe}, 3'h0);
    $display("reset test done");
  endtask
  // each page is programmed once before its erase
  task automatic t_program;
    int full;
    run_op(OP_PROGRAM, 16'h0007, 12'h000, 12'h020, 1'b1);
    fork
      push(32, 8'h40, full);
      wait_done;
    join
    check(full != 0, 1'b1);
    check(flash_u.n_addr, 4);
    check(flash_u.last_cmd, CMD_STATUS);
    check(status_byte, 8'hE0);
    $display("program test done");
  endtask
  task automatic t_readback;
    read_chk(16'h0007, 12'h000, 32, 8'h40);
    read_chk(16'h0007, 12'h01E, 2, 8'h5E);
    read_chk(16'h0003, 12'h000, 1, 8'hFF);
    $display("readback test done");
  endtask
  task automatic t_erase;
    run_op(OP_ERASE, 16'h0007, 12'h000, 12'h000, 1'b1);
    wait_done;
    check(flash_u.n_addr, 2);
    read_chk(16'h0007, 12'h000, 1, 8'hFF);
    $display("erase test done");
  endtask
  task automatic t_refuse;
    int n;
    n = flash_u.n_cmd;
    run_op(OP_PROGRAM, 16'h0001, 12'h000, 12'h004, 1'b0);
    wait_done;
    run_op(OP_ERASE, 16'h0001, 12'h000, 12'h000, 1'b0);
    wait_done;
    check(flash_u.n_cmd, n);
    check(write_protect_n, 1'b0);
    $display("refuse test done");
  endtask
  task automatic t_cmds;
    run_op(OP_RESET, 16'h0000, 12'h000, 12'h000, 1'b1);
    wait_done;
    check(flash_u.last_cmd, CMD_RESET);
    run_op(OP_STATUS, 16'h0000, 12'h000, 12'h000, 1'b1);
    wait_done;
    check(flash_u.last_cmd, CMD_STATUS);
    check(status_byte, 8'hE0);
    $display("command test done");
  endtask
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    op_valid = 1'b0;
    op_code = OP_READ;
    op_column = 12'h000;
    op_page = 16'h0000;
    op_length = 12'h000;
    op_write_enable = 1'b0;
    wr_valid = 1'b0;
    wr_data = 8'h00;
    rd_ready = 1'b0;
    fails = 0;
    checks = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_program;
    t_readback;
    t_erase;
    t_refuse;
    t_cmds;
    finish_test;
  end
  // about four array loads and about seventy bytes fit well inside this span
  initial begin
    #(CLK_NS * 60000);
    fails++;
    $display("[ERR] t=%0t watchdog expired", $time);
    finish_test;
  end
endmodule
`default_nettype wire
